/* hdl/swk_pkg.sv */
/*
 * Package for the STOP-mode wake-up logic: port widths, reset values
 * and the carrier structs that group pin samples and configuration.
 * Assumes a single core clock domain and no register bus.
 */
package swk_pkg;

    // ****************************************
    // Port widths
    // ****************************************
    localparam int SWK_PORTA_W = 4;
    localparam int SWK_PORTB_W = 4;
    localparam int SWK_PORTC_W = 4;
    localparam int SWK_PORTD_W = 4;
    localparam int SWK_PORTE_W = 4;
    localparam int SWK_PORT1A_W = 3;
    localparam int SWK_PORT1B_W = 1;
    localparam int SWK_SYNC_STAGES = 2;

    // ****************************************
    // Reset values
    // ****************************************
    // Pins idle high through pull-ups
    localparam logic SWK_PIN_IDLE = 1'b1;
    localparam logic SWK_WAKE_RST = 1'b0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [SWK_PORTA_W-1:0] wake_input_port_a;
        logic [SWK_PORTB_W-1:0] bit_io_port_b;
        logic [SWK_PORTC_W-1:0] group_io_port_c;
        logic [SWK_PORTD_W-1:0] group_io_port_d;
        logic [SWK_PORTE_W-1:0] matrix_port_e;
        logic [SWK_PORT1A_W-1:0] matrix_port_1a;
        logic [SWK_PORT1B_W-1:0] matrix_port_1b;
        logic int_pin;
    } swk_pins_t;

    typedef struct packed {
        logic [SWK_PORTB_W-1:0] port_b_is_input;
        logic port_c_is_input;
        logic port_d_is_input;
        logic [SWK_PORTE_W-1:0] port_e_is_input;
        logic [SWK_PORT1A_W-1:0] port_1a_is_input;
        logic port_1b_is_input;
        logic key_matrix_en;
        logic [SWK_PORT1A_W-1:0] port_1a_clear_level;
        logic port_1b_clear_level;
        logic interrupt_permit_flag;
    } swk_cfg_t;

    localparam int SWK_PINS_W = $bits(swk_pins_t);

endpackage

/* hdl/swk_sync.sv */
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes the pins may change at any time relative to core_clk.
 */
`timescale 1ns/1ps
module swk_sync
    import swk_pkg::*;
#(
    parameter int WIDTH = SWK_PINS_W
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } swk_sync_state_t;

    swk_sync_state_t state_reg;
    swk_sync_state_t state_next;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("swk_sync: WIDTH must be at least 1");
    end

    always_comb
    begin
        state_next.meta = async_in;
        // First stage feeds only the second stage
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg.meta <= {WIDTH{SWK_PIN_IDLE}};
            state_reg.sync <= {WIDTH{SWK_PIN_IDLE}};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.sync;

endmodule

/* hdl/swk_wake.sv */
/*
 * STOP-mode wake-up detector: synchronises the port and interrupt pins,
 * evaluates each release condition and ORs them into one wake request.
 * Assumes configuration inputs come from core_clk logic and pins are
 * asynchronous; the standby controller consumes stop_wake_req.
 */
// Summary of operation
// - A low level on any of the four input-only port A pins releases STOP unconditionally.
// - A low level on any port B, C or D pin configured as an input releases STOP.
// - Either edge on the interrupt pin releases STOP when the interrupt permit flag is set.
// - With the key matrix selected, a low level on any input port E pin releases STOP.
// - With the key matrix selected, an input port 1A or 1B pin at its clear level releases STOP.
`timescale 1ns/1ps
module swk_wake
    import swk_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Pins
    input wire swk_pins_t pins,
    // Configuration
    input wire swk_cfg_t cfg,
    // Standby controller
    output logic stop_wake_req,
    output logic int_edge_seen
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [SWK_PINS_W-1:0] pins_sync_bits;
    swk_pins_t pins_s;

    swk_sync #(
        .WIDTH(SWK_PINS_W)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(pins),
        .sync_out(pins_sync_bits)
    );

    assign pins_s = swk_pins_t'(pins_sync_bits);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Port 1B is read as one pin and the pin path is fixed at two flops
    if (SWK_PORT1B_W != 1)
    begin : g_bad_port1b
        $error("swk_wake: port 1B must be one pin wide");
    end

    if (SWK_SYNC_STAGES != 2)
    begin : g_bad_sync
        $error("swk_wake: pin synchroniser depth must be two");
    end

    // ****************************************
    // Per-pin release hits
    // ****************************************
    // Output-mode pins show the core's own drive, so their level is masked
    logic [SWK_PORTB_W-1:0] hit_b;
    logic [SWK_PORTE_W-1:0] hit_e;
    logic [SWK_PORT1A_W-1:0] hit_1a;

    for (genvar i = 0; i < SWK_PORTB_W; i++)
    begin : g_hit_b
        assign hit_b[i] = cfg.port_b_is_input[i] & ~pins_s.bit_io_port_b[i];
    end

    for (genvar i = 0; i < SWK_PORTE_W; i++)
    begin : g_hit_e
        assign hit_e[i] = cfg.port_e_is_input[i] & ~pins_s.matrix_port_e[i];
    end

    // Port 1A wakes on a match with its programmed level, not on low
    for (genvar i = 0; i < SWK_PORT1A_W; i++)
    begin : g_hit_1a
        assign hit_1a[i] = cfg.port_1a_is_input[i]
            & ~(pins_s.matrix_port_1a[i] ^ cfg.port_1a_clear_level[i]);
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic int_prev;
        logic wake;
        logic edge_seen;
    } swk_state_t;

    swk_state_t state_reg;
    swk_state_t state_next;

    logic cond_a;
    logic cond_bcd;
    logic cond_int;
    logic cond_e;
    logic cond_1x;
    logic int_edge;

    always_comb
    begin
        cond_a = ~&pins_s.wake_input_port_a;
        cond_bcd = (|hit_b)
            | (cfg.port_c_is_input & ~&pins_s.group_io_port_c)
            | (cfg.port_d_is_input & ~&pins_s.group_io_port_d);
        int_edge = pins_s.int_pin ^ state_reg.int_prev;
        cond_int = int_edge & cfg.interrupt_permit_flag;
        cond_e = cfg.key_matrix_en & (|hit_e);
        cond_1x = cfg.key_matrix_en & (
            (|hit_1a)
            | (cfg.port_1b_is_input
                & ~(pins_s.matrix_port_1b[0] ^ cfg.port_1b_clear_level)));
        // A pin change reaches the request after two sync flops and one output flop
        state_next = state_reg;
        state_next.int_prev = pins_s.int_pin;
        state_next.edge_seen = int_edge;
        // Single OR keeps the standby controller's view simple
        state_next.wake = cond_a | cond_bcd | cond_int | cond_e | cond_1x;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg.int_prev <= SWK_PIN_IDLE;
            state_reg.wake <= SWK_WAKE_RST;
            state_reg.edge_seen <= SWK_WAKE_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign stop_wake_req = state_reg.wake;
    assign int_edge_seen = state_reg.edge_seen;

    // ****************************************
    // Checks
    // ****************************************
    // Checks sample one edge behind the logic, hence the |=> forms
    a_porta_low_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(&pins_s.wake_input_port_a) |=> stop_wake_req)
        else $error("port A low did not raise wake");

    a_portb_input_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        |(cfg.port_b_is_input & ~pins_s.bit_io_port_b) |=> stop_wake_req)
        else $error("port B input low did not raise wake");

    a_portc_input_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.port_c_is_input && !(&pins_s.group_io_port_c)) |=> stop_wake_req)
        else $error("port C input low did not raise wake");

    a_portd_input_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.port_d_is_input && !(&pins_s.group_io_port_d)) |=> stop_wake_req)
        else $error("port D input low did not raise wake");

    sequence s_int_toggle;
        $changed(pins_s.int_pin) && cfg.interrupt_permit_flag;
    endsequence

    a_int_edge_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_int_toggle |=> stop_wake_req && int_edge_seen)
        else $error("permitted interrupt edge did not raise wake");

    a_porte_matrix_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.key_matrix_en && |(cfg.port_e_is_input & ~pins_s.matrix_port_e))
        |=> stop_wake_req)
        else $error("port E matrix low did not raise wake");

    a_port1_level_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.key_matrix_en && cfg.port_1b_is_input
            && pins_s.matrix_port_1b[0] == cfg.port_1b_clear_level)
        |=> stop_wake_req)
        else $error("port 1B clear level did not raise wake");

    a_port1a_level_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.key_matrix_en && |(cfg.port_1a_is_input
            & ~(pins_s.matrix_port_1a ^ cfg.port_1a_clear_level)))
        |=> stop_wake_req)
        else $error("port 1A clear level did not raise wake");

    a_matrix_off_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!cfg.key_matrix_en && (&pins_s.wake_input_port_a)
            && !cfg.interrupt_permit_flag && cfg.port_b_is_input == '0
            && !cfg.port_c_is_input && !cfg.port_d_is_input)
        |=> !stop_wake_req)
        else $error("wake raised with no qualified condition");

    a_wake_has_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(stop_wake_req) |-> $past(cond_a || cond_bcd || cond_int || cond_e || cond_1x))
        else $error("wake rose without a cause");

    // Raw pins are read here only, to check the whole synchroniser path
    sequence s_porta_held;
        (!(&pins.wake_input_port_a)) [*4];
    endsequence

    a_porta_pin_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_porta_held |=> stop_wake_req)
        else $error("held port A pin did not raise wake");

    sequence s_int_raw_edge;
        $changed(pins.int_pin) ##2 cfg.interrupt_permit_flag;
    endsequence

    a_int_pin_wakes: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_int_raw_edge |=> stop_wake_req && int_edge_seen)
        else $error("permitted interrupt pin edge did not raise wake");

    a_edge_pulse_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(pins_s.int_pin) |=> int_edge_seen)
        else $error("synced interrupt edge gave no pulse");

    a_edge_pulse_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        $stable(pins_s.int_pin) |=> !int_edge_seen)
        else $error("interrupt pulse without an edge");

endmodule

/* tb/swk_keypad.sv */
/*
 * Key matrix and interrupt pin model facing the wake-up block.
 * Assumes closed keys pull pins low and open pins sit at pull-ups.
 */
`timescale 1ns/1ps
module swk_keypad
    import swk_pkg::*;
(
    // Key state from bench
    input wire swk_pins_t key_down,
    // Pins to the block
    output wire swk_pins_t pins
);
    // Open keys never hold the last level: the pull-up wins
    assign pins = ~key_down;
endmodule

/* tb/swk_wake_tb.sv */
/*
 * Self-checking bench for the STOP wake-up detector.
 * Assumes swk_keypad as pin model and a 125 MHz core clock.
 */
`timescale 1ns/1ps
module swk_wake_tb
    import swk_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    swk_pins_t key_down = '0;
    swk_pins_t pins;
    swk_cfg_t cfg = '0;
    logic stop_wake_req;
    logic int_edge_seen;
    int n_mismatch = 0;
    int tests_run = 0;

    swk_keypad u_swk_keypad (.key_down(key_down), .pins(pins));
    swk_wake u_swk_wake (.core_clk(core_clk), .sys_rst(sys_rst), .pins(pins), .cfg(cfg),
        .stop_wake_req(stop_wake_req), .int_edge_seen(int_edge_seen));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Two sync flops plus output flop, with margin
    task automatic settle(input logic exp);
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        chk(stop_wake_req, exp);
    endtask

    task automatic t_port_a;
        for (int i = 0; i < SWK_PORTA_W; i++)
        begin
            @(posedge core_clk) key_down.wake_input_port_a[i] <= 1'b1;
            settle(1'b1);
            @(posedge core_clk) key_down.wake_input_port_a[i] <= 1'b0;
            settle(1'b0);
        end
        $display("port a test done");
    endtask

    // Mid-run reset with a key held: outputs clear, then the held key wakes again
    task automatic t_reset;
        @(posedge core_clk) key_down.wake_input_port_a[0] <= 1'b1;
        settle(1'b1);
        @(posedge core_clk) sys_rst <= 1'b1;
        @(negedge core_clk);
        chk(stop_wake_req, SWK_WAKE_RST);
        chk(int_edge_seen, SWK_WAKE_RST);
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(stop_wake_req, 1'b0);
        @(negedge core_clk);
        chk(stop_wake_req, 1'b1);
        @(posedge core_clk) key_down.wake_input_port_a[0] <= 1'b0;
        settle(1'b0);
        $display("reset test done");
    endtask

    task automatic t_bcd;
        @(posedge core_clk) key_down.bit_io_port_b <= 4'h4;
        cfg.port_b_is_input <= 4'hb;
        settle(1'b0);
        @(posedge core_clk) cfg.port_b_is_input <= 4'h4;
        settle(1'b1);
        @(posedge core_clk) key_down.bit_io_port_b <= 4'h0;
        key_down.group_io_port_c <= 4'h8;
        key_down.group_io_port_d <= 4'h1;
        settle(1'b0);
        @(posedge core_clk) cfg.port_c_is_input <= 1'b1;
        settle(1'b1);
        @(posedge core_clk) cfg.port_c_is_input <= 1'b0;
        cfg.port_d_is_input <= 1'b1;
        settle(1'b1);
        @(posedge core_clk) key_down.group_io_port_d <= 4'h0;
        key_down.group_io_port_c <= 4'h0;
        settle(1'b0);
        $display("port b c d test done");
    endtask

    task automatic t_int(input logic permit);
        int nw;
        int ne;
        nw = 0;
        ne = 0;
        @(posedge core_clk) cfg.interrupt_permit_flag <= permit;
        @(posedge core_clk) key_down.int_pin <= ~key_down.int_pin;
        repeat (8)
        begin
            @(negedge core_clk);
            if (stop_wake_req === 1'b1) nw++;
            if (int_edge_seen === 1'b1) ne++;
        end
        chk_cnt(nw, int'(permit));
        chk_cnt(ne, 1);
        $display("interrupt test done");
    endtask

    task automatic t_matrix;
        @(posedge core_clk) key_down.matrix_port_e <= 4'h2;
        cfg.port_e_is_input <= 4'h2;
        settle(1'b0);
        @(posedge core_clk) cfg.key_matrix_en <= 1'b1;
        settle(1'b1);
        @(posedge core_clk) cfg.port_e_is_input <= 4'hd;
        settle(1'b0);
        @(posedge core_clk) key_down.matrix_port_e <= 4'h0;
        cfg.port_1a_is_input <= 3'h7;
        settle(1'b0);
        @(posedge core_clk) cfg.port_1a_clear_level <= 3'h2;
        settle(1'b1);
        @(posedge core_clk) cfg.port_1a_is_input <= 3'h5;
        settle(1'b0);
        @(posedge core_clk) cfg.key_matrix_en <= 1'b0;
        settle(1'b0);
        @(posedge core_clk) cfg.port_1a_clear_level <= 3'h0;
        cfg.port_1b_is_input <= 1'b1;
        cfg.key_matrix_en <= 1'b1;
        key_down.matrix_port_1b <= 1'b1;
        settle(1'b1);
        @(posedge core_clk) cfg.port_1b_clear_level <= 1'b1;
        settle(1'b0);
        $display("key matrix test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #20000;
        n_mismatch++;
        results;
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_port_a;
        t_reset;
        t_bcd;
        t_int(1'b0);
        t_int(1'b1);
        t_matrix;
        results;
    end
endmodule
